// >>> shared/sysflags_map.vh
// Purpose: Bit positions, reset value and encodings for the system flags block
// Assumes: 64-bit flags image, privilege levels 0..3
// Notes: Constants only; no logic here
`ifndef SYSFLAGS_MAP_VH
`define SYSFLAGS_MAP_VH
`define FLG_WIDTH 64
`define FLG_CARRY_POS 0
`define FLG_ONE_POS 1
`define FLG_IRQ_EN_POS 9
`define FLG_IOL_LO 12
`define FLG_IOL_HI 13
`define FLG_NEST_POS 14
`define FLG_RESUME_POS 16
`define FLG_V86_POS 17
`define FLG_ALIGN_POS 18
`define FLG_VIRQ_POS 19
`define FLG_VPEND_POS 20
`define FLG_PROBE_POS 21
// Writable positions: arithmetic and trap bits 11..6,4,2,0 plus system bits
`define FLG_WRITE_MASK 64'h0000_0000_003F_7FD5
`define FLG_RESET_VAL 64'h0000_0000_0000_0002
`define PRIV_LEAST 2'h3
// Flag-image write sources
`define WSRC_NONE 3'h0
`define WSRC_POPF 3'h1
`define WSRC_RETURN_FROM_INTERRUPT 3'h2
`define WSRC_TASK 3'h3
`define WSRC_GATE 3'h4
`endif

// >>> logic/io_priv_check.v
// Purpose: Privilege comparisons for I/O access and alignment faulting
// Assumes: Same-clock inputs, combinational result registered by the caller
// Notes: Kept separate from the flags logic; each check has its own privilege compare
`timescale 1ns/1ns
`include "sysflags_map.vh"
module io_priv_check (
   input wire [1:0] i_priv,
   input wire [1:0] i_io_level,
   input wire i_io_req,
   input wire i_unaligned,
   input wire i_align_flag,
   input wire i_align_mask,
   output wire o_io_fault,
   output wire o_align_fault
);
   // Lower number is more privileged, so equal or lower passes
   assign o_io_fault = i_io_req & (i_priv > i_io_level);
   // Only least-privileged code with both enables set is checked
   assign o_align_fault = i_unaligned & i_align_flag & i_align_mask &
      (i_priv == `PRIV_LEAST);
endmodule

// >>> logic/system_flags_control.v
// Purpose: System-level bits of the 64-bit flags register and their events
// Assumes: One core clock; all inputs come from same-clock pipeline logic
// Notes: Arithmetic flags are stored as written; only system bits act
`timescale 1ns/1ns
`include "sysflags_map.vh"
module system_flags_control (
   input wire I_CLK,
   input wire I_SYS_RST,
   input wire [1:0] I_CURRENT_PRIVILEGE,
   input wire I_V86_EXTENSIONS_ENABLE,
   input wire I_PROTECTED_VIRTUAL_IRQ_ENABLE,
   input wire I_ALIGNMENT_MASK_ENABLE,
   input wire I_LONG_MODE,
   input wire [2:0] I_WR_SRC,
   input wire [63:0] I_WR_DATA,
   input wire I_IRQ_SET,
   input wire I_IRQ_CLR,
   input wire I_INSN_DONE,
   input wire I_IO_REQ,
   input wire I_MEM_UNALIGNED,
   input wire I_MASKABLE_IRQ,
   input wire I_NONMASKABLE_IRQ,
   input wire I_EXCEPTION,
   input wire I_SOFT_INT,
   input wire I_BREAKPOINT_HIT,
   output reg [63:0] O_SYSTEM_FLAGS,
   output reg [63:0] O_STACK_IMAGE,
   output reg O_TAKE_MASKABLE,
   output reg O_TAKE_OTHER,
   output reg O_GENERAL_PROTECTION_FAULT,
   output reg O_DEBUG_TRAP,
   output reg O_ALIGNMENT_FAULT,
   output reg O_NEST_TASK_SWITCH,
   output reg O_LEGACY_EMULATION_MODE_BIT
);
   reg [63:0] flags_q; // Stored image, fixed bits forced on read
   reg [63:0] flags_d;
   reg resume_hold_q; // Resume clear deferred by one successful insn
   reg resume_hold_d;
   wire [1:0] io_level_field = flags_q[`FLG_IOL_HI:`FLG_IOL_LO];
   wire nested_task_bit = flags_q[`FLG_NEST_POS];
   wire restart_suppress_bit = flags_q[`FLG_RESUME_POS];
   wire virtual_irq_pending_bit = flags_q[`FLG_VPEND_POS];
   wire io_fault;
   wire align_fault;
   // Virtual mode active; long mode ignores the v86 extension enable
   wire virt_on = (I_LONG_MODE ? I_PROTECTED_VIRTUAL_IRQ_ENABLE :
      (I_V86_EXTENSIONS_ENABLE | I_PROTECTED_VIRTUAL_IRQ_ENABLE)) &
      (io_level_field != `PRIV_LEAST);
   // Real enable flag may move by pop or set/clear only from sufficient privilege
   wire irq_priv_ok = (I_CURRENT_PRIVILEGE <= io_level_field);
   // Virtual-mode enable set while a virtual interrupt is pending is refused
   wire virq_gp = virt_on & I_IRQ_SET & virtual_irq_pending_bit;
   wire irq_gp = ~virt_on & ~irq_priv_ok & (I_IRQ_SET | I_IRQ_CLR);
   // Keep the stored image clean of reserved bits
   wire [63:0] wr_clean = I_WR_DATA & `FLG_WRITE_MASK;

   io_priv_check u_chk (
      .i_priv(I_CURRENT_PRIVILEGE),
      .i_io_level(io_level_field),
      .i_io_req(I_IO_REQ),
      .i_unaligned(I_MEM_UNALIGNED),
      .i_align_flag(flags_q[`FLG_ALIGN_POS]),
      .i_align_mask(I_ALIGNMENT_MASK_ENABLE),
      .o_io_fault(io_fault),
      .o_align_fault(align_fault)
   );

   // Next flag image; a write or else completion, then enable set/clear effects
   always @* begin
      flags_d = flags_q;
      resume_hold_d = resume_hold_q;
      if (I_WR_SRC == `WSRC_POPF) begin
         // Pop keeps the emulation bit as it was
         flags_d = (wr_clean & ~(64'h1 << `FLG_V86_POS)) |
            (flags_q & (64'h1 << `FLG_V86_POS));
         if (virt_on) begin
            // Real enable untouched; write lands in virtual bit
            flags_d[`FLG_IRQ_EN_POS] = flags_q[`FLG_IRQ_EN_POS];
            flags_d[`FLG_VIRQ_POS] = wr_clean[`FLG_IRQ_EN_POS];
         end else if (!irq_priv_ok) begin
            flags_d[`FLG_IRQ_EN_POS] = flags_q[`FLG_IRQ_EN_POS];
         end
      end else if (I_WR_SRC == `WSRC_RETURN_FROM_INTERRUPT || I_WR_SRC == `WSRC_TASK) begin
         flags_d = wr_clean;
         // Return that sets resume holds it one extra instruction
         resume_hold_d = (I_WR_SRC == `WSRC_RETURN_FROM_INTERRUPT) & wr_clean[`FLG_RESUME_POS];
      end else if (I_WR_SRC == `WSRC_GATE) begin
         flags_d = wr_clean;
         flags_d[`FLG_NEST_POS] = 1'b1;
         resume_hold_d = 1'b1;
      end else if (I_INSN_DONE) begin
         // Successful instruction drops resume unless deferred
         if (resume_hold_q) begin
            resume_hold_d = 1'b0;
         end else begin
            flags_d[`FLG_RESUME_POS] = 1'b0;
         end
      end
      // Enable set/clear instructions
      if (virt_on && !virq_gp && (I_IRQ_SET || I_IRQ_CLR)) begin
         flags_d[`FLG_VIRQ_POS] = I_IRQ_SET;
      end else if (!virt_on && irq_priv_ok && (I_IRQ_SET || I_IRQ_CLR)) begin
         flags_d[`FLG_IRQ_EN_POS] = I_IRQ_SET;
      end
   end

   // Register update and event outputs.
   // Reset is sampled on the clock like every other input, so the
   // Reset release needs no synchroniser of its own.
   // All outputs below are flops, so a consumer sees clean pulses.
   // Each event output is a one-cycle pulse one edge after its cause.
   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         // Stored image keeps only writable positions
         flags_q <= `FLG_RESET_VAL & `FLG_WRITE_MASK;
         resume_hold_q <= 1'b0;
         O_SYSTEM_FLAGS <= `FLG_RESET_VAL;
         O_STACK_IMAGE <= `FLG_RESET_VAL;
         O_TAKE_MASKABLE <= 1'b0;
         O_TAKE_OTHER <= 1'b0;
         O_GENERAL_PROTECTION_FAULT <= 1'b0;
         O_DEBUG_TRAP <= 1'b0;
         O_ALIGNMENT_FAULT <= 1'b0;
         O_NEST_TASK_SWITCH <= 1'b0;
         O_LEGACY_EMULATION_MODE_BIT <= 1'b0;
      end else begin
         // Normal operation: commit the next image every cycle
         flags_q <= flags_d;
         resume_hold_q <= resume_hold_d;
         // Reserved positions forced on every read
         O_SYSTEM_FLAGS <= (flags_d & `FLG_WRITE_MASK) |
            (64'h1 << `FLG_ONE_POS);
         O_LEGACY_EMULATION_MODE_BIT <= flags_d[`FLG_V86_POS];
         O_TAKE_MASKABLE <= I_MASKABLE_IRQ & flags_q[`FLG_IRQ_EN_POS];
         O_TAKE_OTHER <= I_NONMASKABLE_IRQ | I_SOFT_INT | I_EXCEPTION;
         O_GENERAL_PROTECTION_FAULT <= io_fault | virq_gp | irq_gp;
         // Breakpoint retrigger blocked while resume is set
         O_DEBUG_TRAP <= I_BREAKPOINT_HIT & ~restart_suppress_bit;
         O_ALIGNMENT_FAULT <= align_fault;
         // Legacy-mode return from a nested task
         O_NEST_TASK_SWITCH <= (I_WR_SRC == `WSRC_RETURN_FROM_INTERRUPT) & nested_task_bit &
            ~I_LONG_MODE;
         // Stacked image: resume 1 normally, 0 for a breakpoint trap
         O_STACK_IMAGE <= (flags_q & `FLG_WRITE_MASK & ~(64'h1 << `FLG_RESUME_POS)) |
            (64'h1 << `FLG_ONE_POS) |
            ({63'h0, ~(I_BREAKPOINT_HIT & ~restart_suppress_bit)} << `FLG_RESUME_POS);
      end
   end
endmodule

// >>> testbench/system_flags_control_assertions.sv
// Purpose: Port-level checks of the system flags block
// Assumes: One clock, synchronous active-high reset
// Notes: Pulses are judged one edge after their cause
`timescale 1ns/1ns
`include "sysflags_map.vh"
module system_flags_control_assertions (
   input wire I_CLK,
   input wire I_SYS_RST,
   input wire [1:0] I_CURRENT_PRIVILEGE,
   input wire I_ALIGNMENT_MASK_ENABLE,
   input wire [2:0] I_WR_SRC,
   input wire I_IO_REQ,
   input wire I_MEM_UNALIGNED,
   input wire I_MASKABLE_IRQ,
   input wire I_BREAKPOINT_HIT,
   input wire [63:0] O_SYSTEM_FLAGS,
   input wire [63:0] O_STACK_IMAGE,
   input wire O_TAKE_MASKABLE,
   input wire O_GENERAL_PROTECTION_FAULT,
   input wire O_DEBUG_TRAP,
   input wire O_ALIGNMENT_FAULT,
   input wire O_LEGACY_EMULATION_MODE_BIT
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   // I/O attempt from a level weaker than the field allows
   sequence s_io_denied;
      I_IO_REQ && (I_CURRENT_PRIVILEGE > O_SYSTEM_FLAGS[13:12]);
   endsequence
   // Breakpoint while suppression is off must trap and stack a clear resume bit
   sequence s_bp_fresh;
      I_BREAKPOINT_HIT && !O_SYSTEM_FLAGS[16];
   endsequence
   a_io_fault_raised: assert property (s_io_denied |=> O_GENERAL_PROTECTION_FAULT)
      else $error("io fault missing");
   a_mask_irq_gate: assert property (
      I_MASKABLE_IRQ |=> O_TAKE_MASKABLE == $past(O_SYSTEM_FLAGS[9])) else $error("take wrong");
   a_reserved_fixed: assert property (
      (O_SYSTEM_FLAGS & ~`FLG_WRITE_MASK) == 64'h0000_0000_0000_0002) else $error("reserved");
   a_pop_keeps_mode: assert property (
      I_WR_SRC == `WSRC_POPF |=> $stable(O_SYSTEM_FLAGS[17])) else $error("pop moved mode");
   a_mode_out_tracks: assert property (
      O_LEGACY_EMULATION_MODE_BIT == O_SYSTEM_FLAGS[17]) else $error("mode output");
   a_gate_sets_nest: assert property (
      I_WR_SRC == `WSRC_GATE |=> O_SYSTEM_FLAGS[14]) else $error("nest not set");
   a_align_fault_raised: assert property (
      I_MEM_UNALIGNED && O_SYSTEM_FLAGS[18] && I_ALIGNMENT_MASK_ENABLE &&
      I_CURRENT_PRIVILEGE == `PRIV_LEAST |=> O_ALIGNMENT_FAULT) else $error("no align fault");
   a_bp_trap_stack: assert property (
      s_bp_fresh |=> O_DEBUG_TRAP && !O_STACK_IMAGE[16]) else $error("breakpoint trap");
endmodule
bind system_flags_control system_flags_control_assertions chk (.*);

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the system flags block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Directed corners first, then LFSR-driven traffic
`timescale 1ns/1ns
`include "sysflags_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
   logic clk = 0, rst = 1, vme = 0, pvi = 0, am = 0, lm = 0;
   logic is = 0, ic = 0, dn = 0, io = 0, un = 0, mi = 0, nm = 0, ex = 0, si = 0, bp = 0;
   logic tm, ot, gp, db, ac, nt, vm;
   logic [1:0] pr = 0;
   logic [2:0] src = 0;
   logic [63:0] wd = 0, fl, st;
   logic [31:0] lf = 32'h0000_c9f6;   // Random source, fixed seed
   int errors = 0, comparisons = 0;
   system_flags_control uut (.I_CLK(clk), .I_SYS_RST(rst), .I_CURRENT_PRIVILEGE(pr),
      .I_V86_EXTENSIONS_ENABLE(vme), .I_PROTECTED_VIRTUAL_IRQ_ENABLE(pvi),
      .I_ALIGNMENT_MASK_ENABLE(am), .I_LONG_MODE(lm), .I_WR_SRC(src), .I_WR_DATA(wd),
      .I_IRQ_SET(is), .I_IRQ_CLR(ic), .I_INSN_DONE(dn), .I_IO_REQ(io),
      .I_MEM_UNALIGNED(un), .I_MASKABLE_IRQ(mi), .I_NONMASKABLE_IRQ(nm), .I_EXCEPTION(ex),
      .I_SOFT_INT(si), .I_BREAKPOINT_HIT(bp), .O_SYSTEM_FLAGS(fl), .O_STACK_IMAGE(st),
      .O_TAKE_MASKABLE(tm), .O_TAKE_OTHER(ot), .O_GENERAL_PROTECTION_FAULT(gp),
      .O_DEBUG_TRAP(db), .O_ALIGNMENT_FAULT(ac), .O_NEST_TASK_SWITCH(nt),
      .O_LEGACY_EMULATION_MODE_BIT(vm));
   always #25 clk = ~clk;
   // Feedback shift for the random traffic
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Flags after a pop: reserved dropped, bit 1 held, emulation bit kept
   function automatic logic [63:0] popv(input logic [63:0] o, input logic [63:0] d);
      return (d & `FLG_WRITE_MASK & ~64'h0000_0000_0002_0000) |
         (o & 64'h0000_0000_0002_0000) | 64'h0000_0000_0000_0002;
   endfunction
   // One edge samples the request, then all pulses drop
   task go;
      @(posedge clk);
      #1 {src, wd, is, ic, dn, io, un, mi, nm, ex, si, bp} = '0;
   endtask
   task wr(input logic [2:0] s, input logic [63:0] d);
      src = s; wd = d; go;
   endtask
   task end_sim;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog sized well past the ~2040 cycles of the run
   initial begin
      #400_000 errors++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 0;
      `CHK("reset", 64'h0000_0000_0000_0002, fl)
      wr(`WSRC_POPF, '1); `CHK("popall", popv(64'h0000_0000_0000_0002, '1), fl)
      wr(`WSRC_POPF, '0); `CHK("popzero", 64'h0000_0000_0000_0002, fl)
      pr = 3; io = 1; go; `CHK("io3", 1'b1, gp)
      pr = 0; io = 1; go; `CHK("io0", 1'b0, gp)
      wr(`WSRC_GATE, '0); `CHK("nest", 1'b1, fl[14])
      wr(`WSRC_RETURN_FROM_INTERRUPT, '0); `CHK("nestsw", 1'b1, nt)
      bp = 1; go; `CHK("bp", 1'b1, db)
      `CHK("stkbp", 1'b0, st[16])
      ex = 1; go; `CHK("stkex", 1'b1, st[16])
      `CHK("exc", 1'b1, ot)
      wr(`WSRC_RETURN_FROM_INTERRUPT, 64'h0000_0000_0001_0000); dn = 1; bp = 1; go; `CHK("sup", 1'b0, db)
      `CHK("rfhold", 1'b1, fl[16])
      dn = 1; go; `CHK("rfclr", 1'b0, fl[16])
      is = 1; go; mi = 1; go; `CHK("take", 1'b1, tm)
      ic = 1; go; mi = 1; go; `CHK("mask", 1'b0, tm)
      nm = 1; go; `CHK("nmi", 1'b1, ot)
      pr = 3; vme = 1; is = 1; go; `CHK("vif", 2'b10, {fl[19], fl[9]})
      wr(`WSRC_TASK, 64'h0000_0000_0010_0000); is = 1; go; `CHK("vip", 2'b10, {gp, fl[19]})
      wr(`WSRC_TASK, '0); lm = 1; is = 1; go; `CHK("lm", 2'b10, {gp, fl[9]})
      pvi = 1; is = 1; go; `CHK("lmpvi", 1'b1, fl[19])
      {lm, vme, pvi} = '0; wr(`WSRC_TASK, 64'h0000_0000_0004_0000);
      am = 1; un = 1; go; `CHK("al3", 1'b1, ac)
      pr = 2; un = 1; go; `CHK("al2", 1'b0, ac)
      wr(`WSRC_TASK, 64'h0000_0000_0002_0000); `CHK("v86", 1'b1, vm)
      wr(`WSRC_POPF, '0); `CHK("v86pop", 1'b1, vm)
      repeat (2000) begin
         lf = nxt(lf); {bp, si, ex, nm, mi, un, io, dn, am, lm, pvi, vme, pr} = lf[13:0];
         src = (lf[16:14] > 4) ? 3'h0 : lf[16:14]; is = lf[17]; ic = lf[18] & ~lf[17];
         wd = {lf, nxt(lf)}; go; `CHK("rsv", 64'h0000_0000_0000_0002, fl & ~`FLG_WRITE_MASK)
      end
      end_sim;
   end
endmodule
